// file: hdl/sadc_pkg.sv
// constants, register map and state type for the converter digital control
package sadc_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int SAR_W = 10;
    localparam int NUM_RES = 8;
    // register word addresses
    localparam logic [4:0] OFS_MODULE_CFG = 5'h00;
    localparam logic [4:0] OFS_CONV_SETUP = 5'h01;
    localparam logic [4:0] OFS_SEQ_LAUNCH = 5'h02;
    localparam logic [4:0] OFS_CONV_STATUS = 5'h03;
    localparam logic [4:0] OFS_RESULT = 5'h08;
    // field positions
    localparam int CFG_STOP_BIT = 0;
    localparam int CFG_HALT_LSB = 1;
    localparam int SETUP_DIV_LSB = 0;
    localparam int SETUP_STS_LSB = 5;
    localparam int SETUP_TEN_BIT_SELECT_BIT = 7;
    localparam int LAUNCH_CHAN_LSB = 0;
    localparam int LAUNCH_S8_BIT = 4;
    localparam int LAUNCH_MULT_BIT = 5;
    localparam int LAUNCH_SCAN_BIT = 6;
    localparam int STAT_CCF_LSB = 0;
    localparam int STAT_CHAN_LSB = 8;
    localparam int STAT_BUSY_BIT = 14;
    localparam int STAT_SCF_BIT = 15;
    // reset values and codes
    localparam logic [4:0] DIV_RST = 5'h03;
    localparam logic [4:0] DIV_MIN = 5'h01;
    localparam logic [4:0] DIV_RSVD = 5'h00;
    localparam logic [1:0] HALT_IGNORE = 2'h0;
    localparam logic [1:0] HALT_RSVD = 2'h1;
    localparam logic [1:0] HALT_FINISH = 2'h2;
    localparam logic [1:0] HALT_NOW = 2'h3;
    localparam logic [3:0] CH_EXT_MAX = 4'h7;
    localparam logic [3:0] CH_REF_HIGH = 4'hC;
    localparam logic [3:0] CH_REF_LOW = 4'hD;
    localparam logic [3:0] CH_REF_MID = 4'hE;
    // sample phase lengths in converter clocks, SAR bit positions and sequence end indices
    localparam logic [4:0] PH_CAP_CYC = 5'h02;
    localparam logic [4:0] PH_BUF_CYC = 5'h02;
    localparam logic [4:0] PH_DIR_BASE = 5'h02;
    localparam logic [3:0] SAR_MSB = 4'h9;
    localparam logic [3:0] LSB_10 = 4'h0;
    localparam logic [3:0] LSB_8 = 4'h2;
    localparam logic [2:0] SEQ_LAST4 = 3'h3;
    localparam logic [2:0] SEQ_LAST8 = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SAMP_CAP = 3'b001,
        ST_SAMP_BUF = 3'b010,
        ST_SAMP_DIR = 3'b011,
        ST_CONV = 3'b100,
        ST_NEXT = 3'b101
    } sadc_state_e;
endpackage

// file: hdl/sadc_prescaler.sv
// two-stage converter clock prescaler producing a one-cycle tick
`timescale 1ns/1ns
`default_nettype none
module sadc_prescaler #(
    parameter int DIV_W = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic enable,
    input wire logic [DIV_W-1:0] div,
    output logic tick
);
    logic [DIV_W-1:0] cnt_q, cnt_d, div_eff;
    logic half_q, half_d, tick_q, tick_d;

    always_comb begin
        // reserved zero falls back to the smallest legal divide
        div_eff = (div == DIV_W'(sadc_pkg::DIV_RSVD)) ? DIV_W'(sadc_pkg::DIV_MIN) : div; // [R16] [R17]
        cnt_d = cnt_q;
        half_d = half_q;
        tick_d = 1'b0;
        if (clear) begin
            // preload one: the tick register costs a cycle, so the first period would run long
            cnt_d = DIV_W'(1);
            half_d = 1'b0;
        end else if (enable) begin
            if (cnt_q == div_eff) begin // [R15]
                cnt_d = '0;
                half_d = ~half_q;
                tick_d = half_q; // [R16]
            end else begin
                cnt_d = cnt_q + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
            half_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            half_q <= half_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

    AST_TICK_SPACING: assert property (@(posedge clk) disable iff (rst) tick_q |=> !tick_q [*3]) // [R21]
        else $error("converter clock shorter than four system clocks");
endmodule // sadc_prescaler
`default_nettype wire

// file: hdl/sadc_ctrl.sv
// successive-approximation converter digital control, registers and sequencer
// Function
// [R1] debug logic raises halt request during debugging
// [R2] halt field: ignore, reserved, finish, immediate
// [R3] halted: clock and sequencing stop, registers kept
// [R4] halt release resumes at next conversion step
// [R5] channel code picks input, references, or none
// [R6] first two clocks: mux to sample capacitor
// [R7] next two clocks: buffer charges DAC array
// [R8] third phase: mux charges DAC directly
// [R9] bits resolved MSB first from comparator
// [R10] finished value moves into result registers
// [R11] setup write aborts and leaves converter idle
// [R12] launch write aborts and starts new sequence
// [R13] setup and launch registers hold their fields
// [R14] status: sequence, current channel, completion flags
// [R15] first prescaler stage is modulus counter
// [R16] second stage halves; zero divide reserved
// [R17] reserved codes: ignore halt, minimum divide
// [R18] stop bit set at reset, gates, aborts
// [R19] third phase lasts 2, 4, 8, 16 clocks
// [R20] 8 or 10 bit results, right aligned
// [R21] prescaler resets to divide by eight
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module sadc_ctrl (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [sadc_pkg::ADDR_W-1:0] ADDR,
    input wire logic [sadc_pkg::DATA_W-1:0] WR_DATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [sadc_pkg::DATA_W-1:0] RD_DATA,
    input wire logic HALT_REQ,
    input wire logic COMP_IN,
    output logic SAMPLE_CONNECT,
    output logic BUFFER_DRIVE,
    output logic DIRECT_CHARGE,
    output logic [7:0] MUX_EXT,
    output logic MUX_REF_HIGH,
    output logic MUX_REF_LOW,
    output logic MUX_REF_MID,
    output logic [sadc_pkg::SAR_W-1:0] DAC_CODE,
    output logic HALTED
);
    // {mid, low, high, external[7:0]}; reserved codes select nothing
    function automatic logic [10:0] chan_decode(input logic [3:0] ch);
        logic [10:0] sel;
        sel = 11'h000;
        if (ch <= sadc_pkg::CH_EXT_MAX) sel[ch[2:0]] = 1'b1; // [R5]
        else if (ch == sadc_pkg::CH_REF_HIGH) sel[8] = 1'b1;
        else if (ch == sadc_pkg::CH_REF_LOW) sel[9] = 1'b1;
        else if (ch == sadc_pkg::CH_REF_MID) sel[10] = 1'b1;
        return sel;
    endfunction

    logic wr_cfg, wr_setup, wr_launch, halt_now, adv, tick, conv_done;
    logic stop_q, stop_d, ten_bit_select_q, ten_bit_select_d, s8_q, s8_d, mult_q, mult_d, scan_q, scan_d;
    logic [1:0] halt_sel_q, halt_sel_d, sts_q, sts_d;
    logic [4:0] div_q, div_d, dir_len;
    logic [3:0] chan_base_q, chan_base_d;
    logic [sadc_pkg::DATA_W-1:0] rd_q, rd_d, status;
    sadc_pkg::sadc_state_e state_q, state_d;
    logic [4:0] step_q, step_d;
    logic [3:0] bit_q, bit_d, chan_q, chan_d, lsb;
    logic [2:0] idx_q, idx_d, last_idx;
    logic [sadc_pkg::SAR_W-1:0] sar_q, sar_d, sar_n;
    logic [7:0] ccf_q, ccf_d;
    logic scf_q, scf_d, halted_q, samp_q, buf_q, dir_q;
    logic [10:0] sel_q, sel_d;
    logic [sadc_pkg::SAR_W-1:0] dac_q, dac_d;
    logic [sadc_pkg::SAR_W-1:0] result_q [sadc_pkg::NUM_RES];
    logic [sadc_pkg::SAR_W-1:0] result_d [sadc_pkg::NUM_RES];

    assign wr_cfg = WR_EN && (ADDR == sadc_pkg::OFS_MODULE_CFG);
    assign wr_setup = WR_EN && (ADDR == sadc_pkg::OFS_CONV_SETUP);
    assign wr_launch = WR_EN && (ADDR == sadc_pkg::OFS_SEQ_LAUNCH);

    // halt request is trusted to follow debug entry and exit [R1]
    always_comb begin
        halt_now = 1'b0;
        if (HALT_REQ) begin
            case (halt_sel_q)
                sadc_pkg::HALT_NOW: halt_now = 1'b1; // [R2]
                sadc_pkg::HALT_FINISH: halt_now = (state_q == sadc_pkg::ST_IDLE) ||
                                                  (state_q == sadc_pkg::ST_NEXT); // [R2]
                default: halt_now = 1'b0; // [R17]
            endcase
        end
    end

    // a tick while halted is dropped; state simply waits for the next one
    assign adv = tick && !halt_now; // [R3] [R4]

    sadc_prescaler #(.DIV_W(5)) u_prescaler (
        .clk(REF_CLK),
        .rst(RST),
        .clear(stop_q || wr_setup || wr_launch),
        .enable(!stop_q && !halt_now && (state_q != sadc_pkg::ST_IDLE)), // [R18] [R3]
        .div(div_q),
        .tick(tick)
    );

    // register file and read port
    always_comb begin
        stop_d = stop_q;
        halt_sel_d = halt_sel_q;
        div_d = div_q;
        sts_d = sts_q;
        ten_bit_select_d = ten_bit_select_q;
        chan_base_d = chan_base_q;
        s8_d = s8_q;
        mult_d = mult_q;
        scan_d = scan_q;
        if (wr_cfg) begin
            stop_d = WR_DATA[sadc_pkg::CFG_STOP_BIT];
            halt_sel_d = WR_DATA[sadc_pkg::CFG_HALT_LSB +: 2];
        end
        if (wr_setup) begin
            div_d = WR_DATA[sadc_pkg::SETUP_DIV_LSB +: 5]; // [R13]
            sts_d = WR_DATA[sadc_pkg::SETUP_STS_LSB +: 2];
            ten_bit_select_d = WR_DATA[sadc_pkg::SETUP_TEN_BIT_SELECT_BIT];
        end
        if (wr_launch) begin
            chan_base_d = WR_DATA[sadc_pkg::LAUNCH_CHAN_LSB +: 4]; // [R13]
            s8_d = WR_DATA[sadc_pkg::LAUNCH_S8_BIT];
            mult_d = WR_DATA[sadc_pkg::LAUNCH_MULT_BIT];
            scan_d = WR_DATA[sadc_pkg::LAUNCH_SCAN_BIT];
        end
        status = '0;
        status[sadc_pkg::STAT_CCF_LSB +: 8] = ccf_q; // [R14]
        status[sadc_pkg::STAT_CHAN_LSB +: 4] = chan_q;
        status[sadc_pkg::STAT_BUSY_BIT] = (state_q != sadc_pkg::ST_IDLE);
        status[sadc_pkg::STAT_SCF_BIT] = scf_q;
        rd_d = '0;
        if (RD_EN) begin
            if (ADDR[4:3] == sadc_pkg::OFS_RESULT[4:3]) begin
                rd_d[sadc_pkg::SAR_W-1:0] = result_q[ADDR[2:0]];
            end else begin
                case (ADDR)
                    sadc_pkg::OFS_MODULE_CFG: rd_d[2:0] = {halt_sel_q, stop_q};
                    sadc_pkg::OFS_CONV_SETUP: rd_d[7:0] = {ten_bit_select_q, sts_q, div_q};
                    sadc_pkg::OFS_SEQ_LAUNCH: rd_d[6:0] = {scan_q, mult_q, s8_q, chan_base_q};
                    sadc_pkg::OFS_CONV_STATUS: rd_d = status;
                    default: rd_d = '0;
                endcase
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            stop_q <= 1'b1; // [R18]
            halt_sel_q <= sadc_pkg::HALT_IGNORE;
            div_q <= sadc_pkg::DIV_RST; // [R21]
            sts_q <= 2'h0;
            ten_bit_select_q <= 1'b0;
            chan_base_q <= 4'h0;
            s8_q <= 1'b0;
            mult_q <= 1'b0;
            scan_q <= 1'b0;
            rd_q <= '0;
        end else begin
            stop_q <= stop_d;
            halt_sel_q <= halt_sel_d;
            div_q <= div_d;
            sts_q <= sts_d;
            ten_bit_select_q <= ten_bit_select_d;
            chan_base_q <= chan_base_d;
            s8_q <= s8_d;
            mult_q <= mult_d;
            scan_q <= scan_d;
            rd_q <= rd_d;
        end
    end

    // sequencer and approximation register
    assign dir_len = sadc_pkg::PH_DIR_BASE << sts_q; // [R19]
    assign lsb = ten_bit_select_q ? sadc_pkg::LSB_10 : sadc_pkg::LSB_8; // [R20]
    assign last_idx = s8_q ? sadc_pkg::SEQ_LAST8 : sadc_pkg::SEQ_LAST4;

    always_comb begin
        state_d = state_q;
        step_d = step_q;
        bit_d = bit_q;
        idx_d = idx_q;
        chan_d = chan_q;
        sar_d = sar_q;
        ccf_d = ccf_q;
        scf_d = scf_q;
        result_d = result_q;
        conv_done = 1'b0;
        sar_n = sar_q;
        sar_n[bit_q] = COMP_IN; // [R9]
        if (stop_q || wr_setup) begin
            state_d = sadc_pkg::ST_IDLE; // [R11] [R18]
            if (wr_setup) begin
                ccf_d = 8'h00;
                scf_d = 1'b0;
            end
        end else if (wr_launch) begin
            state_d = sadc_pkg::ST_SAMP_CAP; // [R12]
            step_d = 5'h00;
            idx_d = 3'h0;
            chan_d = WR_DATA[sadc_pkg::LAUNCH_CHAN_LSB +: 4];
            ccf_d = 8'h00;
            scf_d = 1'b0;
        end else if (adv) begin
            step_d = step_q + 5'h01;
            case (state_q)
                sadc_pkg::ST_SAMP_CAP: if (step_q == sadc_pkg::PH_CAP_CYC - 5'h01) begin // [R6]
                    state_d = sadc_pkg::ST_SAMP_BUF;
                    step_d = 5'h00;
                end
                sadc_pkg::ST_SAMP_BUF: if (step_q == sadc_pkg::PH_BUF_CYC - 5'h01) begin // [R7]
                    state_d = sadc_pkg::ST_SAMP_DIR;
                    step_d = 5'h00;
                end
                sadc_pkg::ST_SAMP_DIR: if (step_q == dir_len - 5'h01) begin // [R8]
                    state_d = sadc_pkg::ST_CONV;
                    step_d = 5'h00;
                    bit_d = sadc_pkg::SAR_MSB;
                    sar_d = '0;
                    sar_d[sadc_pkg::SAR_MSB] = 1'b1;
                end
                sadc_pkg::ST_CONV: begin
                    step_d = 5'h00;
                    sar_d = sar_n;
                    if (bit_q == lsb) begin
                        conv_done = 1'b1;
                        // 8-bit results drop the two unresolved bits
                        result_d[idx_q] = ten_bit_select_q ? sar_n : {2'h0, sar_n[sadc_pkg::SAR_W-1:2]}; // [R10] [R20]
                        ccf_d[idx_q] = 1'b1; // [R14]
                        idx_d = (idx_q == last_idx) ? 3'h0 : idx_q + 3'h1;
                        if (idx_q == last_idx) scf_d = 1'b1;
                        state_d = (idx_q == last_idx && !scan_q) ? sadc_pkg::ST_IDLE : sadc_pkg::ST_NEXT;
                        chan_d = mult_q ? chan_base_q + {1'b0, idx_d} : chan_base_q;
                    end else begin
                        bit_d = bit_q - 4'h1; // [R9]
                        sar_d[bit_q - 4'h1] = 1'b1;
                    end
                end
                sadc_pkg::ST_NEXT: begin
                    state_d = sadc_pkg::ST_SAMP_CAP;
                    step_d = 5'h00;
                end
                default: state_d = sadc_pkg::ST_IDLE;
            endcase
        end
        sel_d = (state_d == sadc_pkg::ST_IDLE) ? 11'h000 : chan_decode(chan_d); // [R5]
        dac_d = (state_d == sadc_pkg::ST_CONV) ? sar_d : '0;
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_q <= sadc_pkg::ST_IDLE;
            step_q <= 5'h00;
            bit_q <= 4'h0;
            idx_q <= 3'h0;
            chan_q <= 4'h0;
            sar_q <= '0;
            ccf_q <= 8'h00;
            scf_q <= 1'b0;
            for (int i = 0; i < sadc_pkg::NUM_RES; i++) result_q[i] <= '0;
            samp_q <= 1'b0;
            buf_q <= 1'b0;
            dir_q <= 1'b0;
            sel_q <= 11'h000;
            dac_q <= '0;
            halted_q <= 1'b0;
        end else begin
            state_q <= state_d;
            step_q <= step_d;
            bit_q <= bit_d;
            idx_q <= idx_d;
            chan_q <= chan_d;
            sar_q <= sar_d;
            ccf_q <= ccf_d;
            scf_q <= scf_d;
            result_q <= result_d;
            samp_q <= (state_d == sadc_pkg::ST_SAMP_CAP); // [R6]
            buf_q <= (state_d == sadc_pkg::ST_SAMP_BUF); // [R7]
            dir_q <= (state_d == sadc_pkg::ST_SAMP_DIR); // [R8]
            sel_q <= sel_d;
            dac_q <= dac_d;
            halted_q <= halt_now;
        end
    end

    assign RD_DATA = rd_q;
    assign SAMPLE_CONNECT = samp_q;
    assign BUFFER_DRIVE = buf_q;
    assign DIRECT_CHARGE = dir_q;
    assign MUX_EXT = sel_q[7:0];
    assign MUX_REF_HIGH = sel_q[8];
    assign MUX_REF_LOW = sel_q[9];
    assign MUX_REF_MID = sel_q[10];
    assign DAC_CODE = dac_q;
    assign HALTED = halted_q;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence s_launch;
        wr_launch && !stop_q;
    endsequence
    sequence s_fresh_sample;
        state_q == sadc_pkg::ST_SAMP_CAP && step_q == 5'h00 && ccf_q == 8'h00 && !scf_q;
    endsequence

    AST_HALT_ONLY_CODED: assert property (HALTED |-> $past(HALT_REQ) && $past(halt_sel_q[1])) // [R2]
        else $error("halted with ignore or reserved response");
    AST_HALT_NOW: assert property (HALT_REQ && halt_sel_q == sadc_pkg::HALT_NOW |=> HALTED) // [R2]
        else $error("immediate halt not taken");
    AST_FROZEN_HOLD: assert property (halt_now && !WR_EN && !stop_q |=>
        $stable(state_q) && $stable(step_q) && $stable(sar_q) && $stable(ccf_q)) // [R3]
        else $error("sequencer moved while halted");
    AST_LAUNCH_START: assert property (s_launch |=> s_fresh_sample) // [R12]
        else $error("launch write did not restart sequence");
    AST_SETUP_ABORT: assert property (wr_setup |=> state_q == sadc_pkg::ST_IDLE && ccf_q == 8'h00) // [R11]
        else $error("setup write did not abort");
    AST_STOP_IDLE: assert property (stop_q |=> state_q == sadc_pkg::ST_IDLE && !SAMPLE_CONNECT) // [R18]
        else $error("conversion running while stopped");
    AST_CAP_OUTPUT: assert property (SAMPLE_CONNECT == (state_q == sadc_pkg::ST_SAMP_CAP) &&
        BUFFER_DRIVE == (state_q == sadc_pkg::ST_SAMP_BUF)) // [R6] [R7]
        else $error("sample switches disagree with phase");
    AST_DIRECT_LEN: assert property (state_q == sadc_pkg::ST_CONV && $past(state_q) == sadc_pkg::ST_SAMP_DIR
        |-> $past(step_q) == $past(dir_len) - 5'h01) // [R8] [R19]
        else $error("direct phase length wrong");
    AST_DONE_FLAG: assert property (conv_done && !WR_EN |=> ccf_q[$past(idx_q)]) // [R10]
        else $error("completion flag not set after conversion");
endmodule // sadc_ctrl
`default_nettype wire

// file: testbench/sadc_afe_model.sv
// analog front end model: input mux, sample hold and comparator
`timescale 1ns/1ns
`default_nettype none
module sadc_afe_model (
    input wire logic clk,
    input wire logic [7:0] mux_ext,
    input wire logic mux_ref_high,
    input wire logic mux_ref_low,
    input wire logic mux_ref_mid,
    input wire logic sample_connect,
    input wire logic [9:0] dac_code,
    input wire logic [7:0][9:0] ext_level,
    output logic comp_out
);
    logic [9:0] sel;
    logic [9:0] held;
    // low reference and an unselected mux both read as zero
    always_comb begin
        sel = 10'h000;
        for (int i = 0; i < 8; i++) begin
            if (mux_ext[i]) sel = ext_level[i];
        end
        if (mux_ref_high) sel = 10'h3FF;
        if (mux_ref_low) sel = 10'h000;
        if (mux_ref_mid) sel = 10'h200;
    end
    // charge loss while halted is not modelled, so results stay exact
    always_ff @(posedge clk) begin
        if (sample_connect) held <= sel;
    end
    assign comp_out = (held >= dac_code);
endmodule // sadc_afe_model
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the converter digital control
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam logic [4:0] A_CFG = sadc_pkg::OFS_MODULE_CFG;
    localparam logic [4:0] A_SET = sadc_pkg::OFS_CONV_SETUP;
    localparam logic [4:0] A_LAU = sadc_pkg::OFS_SEQ_LAUNCH;
    localparam logic [4:0] A_STA = sadc_pkg::OFS_CONV_STATUS;
    localparam logic [4:0] A_RES = sadc_pkg::OFS_RESULT;
    logic REF_CLK = 1'b0;
    logic RST = 1'b1;
    logic [4:0] ADDR = 5'h00;
    logic [15:0] WR_DATA = 16'h0000;
    logic WR_EN = 1'b0;
    logic RD_EN = 1'b0;
    logic HALT_REQ = 1'b0;
    logic [15:0] RD_DATA;
    logic COMP_IN, SAMPLE_CONNECT, BUFFER_DRIVE, DIRECT_CHARGE, MUX_REF_HIGH, MUX_REF_LOW, MUX_REF_MID, HALTED;
    logic [7:0] MUX_EXT;
    logic [9:0] DAC_CODE;
    logic [7:0][9:0] lvl = {10'h3C1, 10'h2E7, 10'h1B4, 10'h0F9, 10'h155, 10'h2AA, 10'h301, 10'h08D};
    int n_errors = 0;
    int checks_done = 0;

    sadc_ctrl dut_u (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN),
        .RD_EN(RD_EN), .RD_DATA(RD_DATA), .HALT_REQ(HALT_REQ), .COMP_IN(COMP_IN),
        .SAMPLE_CONNECT(SAMPLE_CONNECT), .BUFFER_DRIVE(BUFFER_DRIVE), .DIRECT_CHARGE(DIRECT_CHARGE),
        .MUX_EXT(MUX_EXT), .MUX_REF_HIGH(MUX_REF_HIGH), .MUX_REF_LOW(MUX_REF_LOW),
        .MUX_REF_MID(MUX_REF_MID), .DAC_CODE(DAC_CODE), .HALTED(HALTED));
    sadc_afe_model afe_u (.clk(REF_CLK), .mux_ext(MUX_EXT), .mux_ref_high(MUX_REF_HIGH),
        .mux_ref_low(MUX_REF_LOW), .mux_ref_mid(MUX_REF_MID), .sample_connect(SAMPLE_CONNECT),
        .dac_code(DAC_CODE), .ext_level(lvl), .comp_out(COMP_IN));

    initial begin
        forever #2 REF_CLK = ~REF_CLK;
    end

    task automatic complete_run();
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        WR_DATA <= d;
        WR_EN <= 1'b1;
        @(posedge REF_CLK);
        WR_EN <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        RD_EN <= 1'b1;
        @(posedge REF_CLK);
        RD_EN <= 1'b0;
        #1 d = RD_DATA;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd(a, v);
        chk(v, exp);
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask
    function automatic logic phase(input int w);
        return w == 0 ? SAMPLE_CONNECT : (w == 1 ? BUFFER_DRIVE : DIRECT_CHARGE);
    endfunction
    // counts the cycles one phase output stands high
    task automatic meas(input int w, input int exp);
        int n;
        int t;
        n = 0;
        t = 0;
        #1;
        while (phase(w) !== 1'b1 && t < 3000) begin
            cycles(1);
            t++;
        end
        while (phase(w) === 1'b1 && n < 3000) begin
            cycles(1);
            n++;
        end
        chk(16'(n), 16'(exp));
    endtask
    // polling the status word keeps the bound independent of the divider
    task automatic wait_done();
        logic [15:0] v;
        int t;
        v = 16'h0000;
        t = 0;
        while (v[15] !== 1'b1 && t < 3000) begin
            rd(A_STA, v);
            t++;
        end
        chk({15'h0, v[15]}, 16'h0001);
    endtask

    initial begin
        #(4 * 80000);
        n_errors++;
        complete_run();
    end

    initial begin
        logic [15:0] v;
        logic [15:0] s;
        logic [15:0] setups [3];
        int chans [3];
        int per;
        int ex;
        setups = '{16'h0003, 16'h00E0, 16'h003F};
        chans = '{3, 5, 6};
        repeat (5) @(posedge REF_CLK);
        RST <= 1'b0;
        rd_chk(A_CFG, 16'h0001);
        rd_chk(A_SET, 16'h0003);
        rd_chk(A_STA, 16'h0000);
        rd_chk(5'h04, 16'h0000);
        wr(A_LAU, 16'h0003);
        cycles(20);
        chk({15'h0, SAMPLE_CONNECT}, 16'h0000);
        wr(A_CFG, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            wr(A_SET, setups[k]);
            wr(A_LAU, 16'(chans[k]));
            per = 2 * ((setups[k][4:0] == 5'h00 ? 1 : int'(setups[k][4:0])) + 1);
            meas(0, 2 * per);
            meas(1, 2 * per);
            meas(2, (2 << setups[k][6:5]) * per);
            wait_done();
            ex = setups[k][7] ? lvl[chans[k]] : lvl[chans[k]] >> 2;
            for (int r = 0; r < 4; r++) begin
                rd_chk(A_RES + 5'(r), 16'(ex));
            end
            rd_chk(A_STA, 16'h800F | 16'(chans[k] << 8));
        end
        wr(A_SET, 16'h0083);
        for (int c = 0; c < 16; c++) begin
            wr(A_LAU, 16'(c));
            cycles(2);
            s = c < 8 ? 16'h0001 << c : (c > 11 && c < 15 ? 16'h1000 >> (c - 10) : 16'h0000);
            chk({5'h00, MUX_REF_HIGH, MUX_REF_LOW, MUX_REF_MID, MUX_EXT}, s);
        end
        wr(A_SET, 16'h0083);
        cycles(30);
        chk({13'h0, SAMPLE_CONNECT, BUFFER_DRIVE, DIRECT_CHARGE}, 16'h0000);
        rd(A_STA, v);
        chk(v & 16'hC0FF, 16'h0000);
        wr(A_CFG, 16'h0006);
        wr(A_LAU, 16'h0002);
        cycles(60);
        @(posedge REF_CLK);
        HALT_REQ <= 1'b1;
        cycles(3);
        chk({15'h0, HALTED}, 16'h0001);
        s = {6'h00, DAC_CODE};
        rd(A_STA, v);
        cycles(40);
        chk({6'h00, DAC_CODE}, s);
        rd_chk(A_STA, v);
        @(posedge REF_CLK);
        HALT_REQ <= 1'b0;
        wait_done();
        rd_chk(A_RES, 16'(lvl[2]));
        for (int h = 0; h < 3; h++) begin
            wr(A_CFG, 16'(h << 1));
            wr(A_LAU, 16'h0001);
            cycles(10);
            @(posedge REF_CLK);
            HALT_REQ <= 1'b1;
            cycles(4);
            chk({15'h0, HALTED}, 16'h0000);
            if (h == 2) begin
                for (int t = 0; t < 300 && HALTED !== 1'b1; t++) begin
                    cycles(1);
                end
                chk({15'h0, HALTED}, 16'h0001);
            end
            @(posedge REF_CLK);
            HALT_REQ <= 1'b0;
        end
        wr(A_LAU, 16'h0030);
        wait_done();
        for (int r = 0; r < 8; r++) begin
            rd_chk(A_RES + 5'(r), 16'(lvl[r]));
        end
        rd(A_STA, v);
        chk(v & 16'hC0FF, 16'h80FF);
        wr(A_LAU, 16'h0047);
        wait_done();
        rd(A_STA, v);
        chk(v & 16'hC000, 16'hC000);
        wr(A_CFG, 16'h0001);
        cycles(2);
        chk({13'h0, SAMPLE_CONNECT, BUFFER_DRIVE, DIRECT_CHARGE}, 16'h0000);
        rd(A_STA, v);
        chk(v & 16'h4000, 16'h0000);
        cycles(4);
        complete_run();
    end
endmodule // tb
`default_nettype wire
